/* fault_resp_pkg.sv */
// package: register map, field layout, reset values and timing of the fault response block
package fault_resp_pkg;
  // register byte addresses (byte address = offset)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SW_FREQ_OFS = 8'h04;
  localparam logic [7:0] LIMIT_DELAY_OFS = 8'h08;
  localparam logic [7:0] FB_LOW_OFS = 8'h0c;
  localparam logic [7:0] FB_HIGH_OFS = 8'h10;
  localparam logic [7:0] CURRENT_OFS = 8'h14;
  localparam logic [7:0] RATED_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h24;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h28;
  localparam logic [7:0] FB_SCALED_OFS = 8'h2c;
  // control register fields
  localparam int NOISE_LSB = 0;
  localparam int NO_LOAD_BIT = 2;
  localparam int MAINS_LSB = 3;
  localparam int OT_BIT = 5;
  localparam int TRIP_CLR_BIT = 8;
  // status register fields
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_CAUSE_LSB = 1;
  localparam int ST_WARN_BIT = 4;
  localparam int ST_DERATE_BIT = 5;
  localparam int ST_OT_LSB = 6;
  localparam int ST_SW_LSB = 16;
  // selector encodings
  localparam logic [1:0] NOISE_ADAPTIVE = 2'h0;
  localparam logic [1:0] NOISE_FIXED = 2'h1;
  localparam logic [1:0] NOISE_FILTER = 2'h2;
  localparam logic NO_LOAD_TRIP = 1'h0;
  localparam logic NO_LOAD_WARN = 1'h1;
  localparam logic [1:0] MAINS_TRIP = 2'h0;
  localparam logic [1:0] MAINS_DERATE = 2'h1;
  localparam logic [1:0] MAINS_WARN = 2'h2;
  localparam logic OT_TRIP = 1'h0;
  localparam logic OT_DERATE = 1'h1;
  // trip causes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_NO_LOAD = 3'h1;
  localparam logic [2:0] CAUSE_MAINS = 3'h2;
  localparam logic [2:0] CAUSE_OVERTEMP = 3'h3;
  localparam logic [2:0] CAUSE_LIMIT = 3'h4;
  // interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_NO_LOAD = 1;
  localparam int IRQ_MAINS = 2;
  localparam int IRQ_OVERTEMP = 3;
  localparam int IRQ_LIMIT = 4;
  // reset values
  localparam logic [15:0] SW_FREQ_RST = 16'h1194;
  localparam logic [5:0] LIMIT_DELAY_RST = 6'h3d;
  localparam logic [5:0] LIMIT_DELAY_OFF = 6'h3d;
  localparam logic signed [31:0] FB_LOW_RST = 32'sh0;
  localparam logic signed [31:0] FB_HIGH_RST = 32'sh000186a0;
  localparam logic [15:0] LIM_THR_RST = 16'hffff;
  localparam logic [15:0] LOW_THR_RST = 16'h0000;
  localparam logic [15:0] RATED_RST = 16'h03e8;
  // frequencies in Hz, percentages of current
  localparam logic [15:0] HSW_DERATE_HZ = 16'h1194;
  localparam logic [15:0] SW_FREQ_MIN_HZ = 16'h07d0;
  localparam logic [15:0] FREQ_DIV = 16'h000a;
  localparam logic [31:0] MAINS_DERATE_PCT = 32'h0000001e;
  localparam logic [31:0] HSW_DERATE_PCT = 32'h0000005a;
  localparam logic [15:0] OT_CAP_STEP = 16'h0032;
  localparam logic signed [63:0] FB_FULL = 64'sh0000000000000fff;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int SECOND_MS = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * SECOND_MS;
  localparam int TICK_W = 28;
  localparam logic [3:0] MAINS_TRIP_S = 4'h3;

  typedef enum logic [1:0] {OT_NORMAL, OT_LOW_SW, OT_CURBACK} ot_state_t;

  typedef struct packed {
    logic [1:0] noise_sel;
    logic no_load_sel;
    logic [1:0] mains_sel;
    logic ot_sel;
    logic [15:0] sw_set;
    logic [5:0] limit_delay;
    logic signed [31:0] fb_low;
    logic signed [31:0] fb_high;
    logic [15:0] lim_thr;
    logic [15:0] low_thr;
    logic [15:0] rated;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [TICK_W-1:0] tick_cnt;
    logic [5:0] lim_secs;
    logic [3:0] mains_secs;
    ot_state_t ot;
    logic [15:0] ot_cap;
    logic tripped;
    logic [2:0] trip_cause;
    logic [15:0] sw_freq;
    logic [15:0] freq_out;
    logic [15:0] cur_cap;
    logic motor_stop;
    logic warning;
    logic alarm;
    logic derate;
    logic irq;
    logic [31:0] rd_data;
    logic signed [31:0] fb_scaled;
  } state_t;
endpackage

/* drive_fault_response.sv */
// drive fault response: switching policy, frequency clamp, protection responses, feedback scaling
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module drive_fault_response #(
  parameter int TICK_CYCLES = fault_resp_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // power stage and monitors
  input wire logic [15:0] out_current,
  input wire logic [15:0] freq_cmd,
  input wire logic mains_fault,
  input wire logic overtemp,
  input wire logic [11:0] feedback_raw,
  // drive commands and indications
  output logic [15:0] sw_freq,
  output logic [15:0] freq_out,
  output logic [15:0] cur_cap,
  output logic motor_stop,
  output logic warning,
  output logic alarm,
  output logic derate,
  output logic irq
);
  localparam int TICK_W = fault_resp_pkg::TICK_W;
  localparam int IRQ_W = fault_resp_pkg::IRQ_W;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  fault_resp_pkg::state_t s_reg;
  fault_resp_pkg::state_t s_next;

  logic tick;
  logic low_cur;
  logic at_limit;
  logic [15:0] sw_act;
  logic [15:0] cap_tmp;
  logic [15:0] mains_cap;
  logic [15:0] hsw_cap;
  logic lim_expire;
  logic mains_expire;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic signed [63:0] fb_prod;
  logic [2:0] cause;

  always_comb begin
    s_next = s_reg;
    tick = (s_reg.tick_cnt == TICK_LAST);
    low_cur = (out_current < s_reg.low_thr);
    at_limit = (out_current >= s_reg.lim_thr);
    clr = '0;
    ev = '0;
    cause = fault_resp_pkg::CAUSE_NONE;
    s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        fault_resp_pkg::CTRL_OFS: begin
          s_next.noise_sel = reg_wdata[fault_resp_pkg::NOISE_LSB +: 2];
          s_next.no_load_sel = reg_wdata[fault_resp_pkg::NO_LOAD_BIT];
          s_next.mains_sel = reg_wdata[fault_resp_pkg::MAINS_LSB +: 2];
          s_next.ot_sel = reg_wdata[fault_resp_pkg::OT_BIT];
          if (reg_wdata[fault_resp_pkg::TRIP_CLR_BIT]) begin
            s_next.tripped = 1'b0;
            s_next.trip_cause = fault_resp_pkg::CAUSE_NONE;
          end
        end
        fault_resp_pkg::SW_FREQ_OFS: s_next.sw_set = reg_wdata[15:0];
        fault_resp_pkg::LIMIT_DELAY_OFS: s_next.limit_delay = reg_wdata[5:0];
        fault_resp_pkg::FB_LOW_OFS: s_next.fb_low = reg_wdata;
        fault_resp_pkg::FB_HIGH_OFS: s_next.fb_high = reg_wdata;
        fault_resp_pkg::CURRENT_OFS: begin
          s_next.lim_thr = reg_wdata[15:0];
          s_next.low_thr = reg_wdata[31:16];
        end
        fault_resp_pkg::RATED_OFS: s_next.rated = reg_wdata[15:0];
        fault_resp_pkg::IRQ_CLEAR_OFS: clr = reg_wdata[IRQ_W-1:0];
        fault_resp_pkg::IRQ_ENABLE_OFS: s_next.irq_en = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // current-limit cut-out timer
    if (!at_limit) begin
      s_next.lim_secs = '0;
    end else if (tick && s_reg.lim_secs != 6'h3f) begin
      s_next.lim_secs = s_reg.lim_secs + 1'b1;
    end
    lim_expire = at_limit && (s_reg.limit_delay != fault_resp_pkg::LIMIT_DELAY_OFF) &&
                 (s_reg.lim_secs >= s_reg.limit_delay);

    // mains failure timer
    if (!mains_fault) begin
      s_next.mains_secs = '0;
    end else if (tick && s_reg.mains_secs != 4'hf) begin
      s_next.mains_secs = s_reg.mains_secs + 1'b1;
    end
    mains_expire = mains_fault && (s_reg.mains_secs >= fault_resp_pkg::MAINS_TRIP_S);

    // overtemperature autoderate sequence
    case (s_reg.ot)
      fault_resp_pkg::OT_NORMAL: begin
        s_next.ot_cap = s_reg.lim_thr;
        if (overtemp && s_reg.ot_sel == fault_resp_pkg::OT_DERATE) begin
          s_next.ot = fault_resp_pkg::OT_LOW_SW;
        end
      end
      fault_resp_pkg::OT_LOW_SW: begin
        if (!overtemp || s_reg.ot_sel != fault_resp_pkg::OT_DERATE) begin
          s_next.ot = fault_resp_pkg::OT_NORMAL;
        end else if (tick) begin
          s_next.ot = fault_resp_pkg::OT_CURBACK;
        end
      end
      fault_resp_pkg::OT_CURBACK: begin
        if (!overtemp || s_reg.ot_sel != fault_resp_pkg::OT_DERATE) begin
          s_next.ot = fault_resp_pkg::OT_NORMAL;
        end else if (tick) begin
          s_next.ot_cap = (s_reg.ot_cap > fault_resp_pkg::OT_CAP_STEP) ?
                          s_reg.ot_cap - fault_resp_pkg::OT_CAP_STEP : '0;
        end
      end
      default: s_next.ot = fault_resp_pkg::OT_NORMAL;
    endcase

    // switching frequency policy
    sw_act = s_reg.sw_set;
    if (s_reg.ot == fault_resp_pkg::OT_LOW_SW || s_reg.ot == fault_resp_pkg::OT_CURBACK) begin
      if (s_reg.noise_sel != fault_resp_pkg::NOISE_FILTER && sw_act > fault_resp_pkg::SW_FREQ_MIN_HZ) begin
        sw_act = fault_resp_pkg::SW_FREQ_MIN_HZ;
      end
    end
    s_next.sw_freq = sw_act;
    s_next.freq_out = (freq_cmd > sw_act / fault_resp_pkg::FREQ_DIV) ?
                      sw_act / fault_resp_pkg::FREQ_DIV : freq_cmd;

    // current capability
    mains_cap = 16'(32'(s_reg.rated) * fault_resp_pkg::MAINS_DERATE_PCT / 32'h64);
    hsw_cap = 16'(32'(s_reg.lim_thr) * fault_resp_pkg::HSW_DERATE_PCT / 32'h64);
    cap_tmp = s_reg.lim_thr;
    s_next.derate = 1'b0;
    if (s_reg.noise_sel != fault_resp_pkg::NOISE_ADAPTIVE && sw_act > fault_resp_pkg::HSW_DERATE_HZ) begin
      cap_tmp = hsw_cap;
      s_next.derate = 1'b1;
    end
    if (mains_fault && s_reg.mains_sel == fault_resp_pkg::MAINS_DERATE && mains_cap < cap_tmp) begin
      cap_tmp = mains_cap;
    end
    if (s_reg.ot == fault_resp_pkg::OT_CURBACK && s_reg.ot_cap < cap_tmp) begin
      cap_tmp = s_reg.ot_cap;
    end
    if ((mains_fault && s_reg.mains_sel == fault_resp_pkg::MAINS_DERATE) ||
        s_reg.ot != fault_resp_pkg::OT_NORMAL) begin
      s_next.derate = 1'b1;
    end
    s_next.cur_cap = cap_tmp;

    // trip decisions, first cause kept until cleared
    if (low_cur && s_reg.no_load_sel == fault_resp_pkg::NO_LOAD_TRIP) begin
      cause = fault_resp_pkg::CAUSE_NO_LOAD;
    end else if (mains_expire && s_reg.mains_sel == fault_resp_pkg::MAINS_TRIP) begin
      cause = fault_resp_pkg::CAUSE_MAINS;
    end else if (overtemp && s_reg.ot_sel == fault_resp_pkg::OT_TRIP) begin
      cause = fault_resp_pkg::CAUSE_OVERTEMP;
    end else if (lim_expire) begin
      cause = fault_resp_pkg::CAUSE_LIMIT;
    end
    if (cause != fault_resp_pkg::CAUSE_NONE && !s_reg.tripped) begin
      s_next.tripped = 1'b1;
      s_next.trip_cause = cause;
    end
    s_next.motor_stop = s_next.tripped;
    s_next.alarm = s_next.tripped;
    s_next.warning = (low_cur && s_reg.no_load_sel == fault_resp_pkg::NO_LOAD_WARN) ||
                     (mains_fault && s_reg.mains_sel != fault_resp_pkg::MAINS_TRIP) ||
                     (s_reg.ot != fault_resp_pkg::OT_NORMAL);

    // interrupt events: set wins over clear
    ev[fault_resp_pkg::IRQ_TRIP] = s_next.tripped && !s_reg.tripped;
    ev[fault_resp_pkg::IRQ_NO_LOAD] = low_cur;
    ev[fault_resp_pkg::IRQ_MAINS] = mains_fault;
    ev[fault_resp_pkg::IRQ_OVERTEMP] = overtemp;
    ev[fault_resp_pkg::IRQ_LIMIT] = lim_expire;
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_en);

    // feedback scaling, fb_low at raw 0 up to fb_high at raw full scale
    fb_prod = 64'(s_reg.fb_high - s_reg.fb_low) * 64'(feedback_raw);
    s_next.fb_scaled = s_reg.fb_low + 32'(fb_prod / fault_resp_pkg::FB_FULL);

    // read data, one cycle after the strobe
    s_next.rd_data = '0;
    if (reg_rd) begin
      case (reg_addr)
        fault_resp_pkg::CTRL_OFS: s_next.rd_data = {26'h0, s_reg.ot_sel, s_reg.mains_sel,
                                                    s_reg.no_load_sel, s_reg.noise_sel};
        fault_resp_pkg::SW_FREQ_OFS: s_next.rd_data = {16'h0, s_reg.sw_set};
        fault_resp_pkg::LIMIT_DELAY_OFS: s_next.rd_data = {26'h0, s_reg.limit_delay};
        fault_resp_pkg::FB_LOW_OFS: s_next.rd_data = s_reg.fb_low;
        fault_resp_pkg::FB_HIGH_OFS: s_next.rd_data = s_reg.fb_high;
        fault_resp_pkg::CURRENT_OFS: s_next.rd_data = {s_reg.low_thr, s_reg.lim_thr};
        fault_resp_pkg::RATED_OFS: s_next.rd_data = {16'h0, s_reg.rated};
        fault_resp_pkg::STATUS_OFS: begin
          s_next.rd_data[fault_resp_pkg::ST_TRIP_BIT] = s_reg.tripped;
          s_next.rd_data[fault_resp_pkg::ST_CAUSE_LSB +: 3] = s_reg.trip_cause;
          s_next.rd_data[fault_resp_pkg::ST_WARN_BIT] = s_reg.warning;
          s_next.rd_data[fault_resp_pkg::ST_DERATE_BIT] = s_reg.derate;
          s_next.rd_data[fault_resp_pkg::ST_OT_LSB +: 2] = s_reg.ot;
          s_next.rd_data[fault_resp_pkg::ST_SW_LSB +: 16] = s_reg.sw_freq;
        end
        fault_resp_pkg::IRQ_STATUS_OFS: s_next.rd_data = {27'h0, s_reg.irq_stat};
        fault_resp_pkg::IRQ_ENABLE_OFS: s_next.rd_data = {27'h0, s_reg.irq_en};
        fault_resp_pkg::FB_SCALED_OFS: s_next.rd_data = s_reg.fb_scaled;
        default: s_next.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.no_load_sel <= fault_resp_pkg::NO_LOAD_WARN;
      s_reg.sw_set <= fault_resp_pkg::SW_FREQ_RST;
      s_reg.limit_delay <= fault_resp_pkg::LIMIT_DELAY_RST;
      s_reg.fb_low <= fault_resp_pkg::FB_LOW_RST;
      s_reg.fb_high <= fault_resp_pkg::FB_HIGH_RST;
      s_reg.lim_thr <= fault_resp_pkg::LIM_THR_RST;
      s_reg.low_thr <= fault_resp_pkg::LOW_THR_RST;
      s_reg.rated <= fault_resp_pkg::RATED_RST;
      s_reg.ot <= fault_resp_pkg::OT_NORMAL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rd_data;
  assign sw_freq = s_reg.sw_freq;
  assign freq_out = s_reg.freq_out;
  assign cur_cap = s_reg.cur_cap;
  assign motor_stop = s_reg.motor_stop;
  assign warning = s_reg.warning;
  assign alarm = s_reg.alarm;
  assign derate = s_reg.derate;
  assign irq = s_reg.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // checks on the registered outputs and state, one cycle after the cause; a_freq_clamp and a_limit_off check in the same cycle

  a_freq_clamp: assert property (freq_out <= sw_freq / fault_resp_pkg::FREQ_DIV)
    else $error("output frequency above a tenth of switching frequency");
  a_fixed_sw_hold: assert property ((s_reg.noise_sel == fault_resp_pkg::NOISE_FIXED &&
    s_reg.ot == fault_resp_pkg::OT_NORMAL) |=> sw_freq == $past(s_reg.sw_set))
    else $error("fixed switching frequency not held at setting");
  a_adaptive_max: assert property ((s_reg.noise_sel == fault_resp_pkg::NOISE_ADAPTIVE &&
    s_reg.ot == fault_resp_pkg::OT_NORMAL && !mains_fault) |=> !derate && sw_freq == $past(s_reg.sw_set))
    else $error("adaptive mode derated or lowered switching frequency");
  a_hsw_derate: assert property ((s_reg.noise_sel == fault_resp_pkg::NOISE_FIXED &&
    sw_act > fault_resp_pkg::HSW_DERATE_HZ) |=> derate)
    else $error("high switching frequency without derating");
  a_noload_trip: assert property ((out_current < s_reg.low_thr && !s_reg.tripped &&
    s_reg.no_load_sel == fault_resp_pkg::NO_LOAD_TRIP) |=> motor_stop)
    else $error("low current did not trip");
  a_noload_warn: assert property ((out_current < s_reg.low_thr && !s_reg.tripped &&
    s_reg.no_load_sel == fault_resp_pkg::NO_LOAD_WARN) |=> warning && !motor_stop)
    else $error("low current warning missing or motor stopped");
  a_mains_cap: assert property ((mains_fault && s_reg.mains_sel == fault_resp_pkg::MAINS_DERATE) |=>
    warning && cur_cap <= 16'(32'($past(s_reg.rated)) * 32'h1e / 32'h64))
    else $error("mains autoderate cap or warning wrong");
  a_mains_wait: assert property ((mains_fault && s_reg.mains_secs < fault_resp_pkg::MAINS_TRIP_S &&
    s_reg.mains_sel == fault_resp_pkg::MAINS_TRIP && !s_reg.tripped && !overtemp && !low_cur && !lim_expire)
    |=> !motor_stop)
    else $error("mains trip before delay");
  a_mains_warn: assert property ((mains_fault && s_reg.mains_sel == fault_resp_pkg::MAINS_WARN) |=>
    warning)
    else $error("mains warning missing");
  a_ot_trip: assert property ((overtemp && s_reg.ot_sel == fault_resp_pkg::OT_TRIP && !reg_wr) |=>
    motor_stop && alarm)
    else $error("overtemperature did not trip with alarm");
  a_ot_lower_sw: assert property ((s_reg.ot == fault_resp_pkg::OT_LOW_SW &&
    s_reg.noise_sel != fault_resp_pkg::NOISE_FILTER) |=> sw_freq <= fault_resp_pkg::SW_FREQ_MIN_HZ && warning)
    else $error("overtemperature did not lower switching frequency");
  a_limit_off: assert property ((s_reg.limit_delay == fault_resp_pkg::LIMIT_DELAY_OFF) |-> !lim_expire)
    else $error("cut-out while delay is off");
  a_limit_expire: assert property ((lim_expire && !s_reg.tripped && !reg_wr) |=> motor_stop)
    else $error("limit delay expiry without cut-out");
  a_limit_clear: assert property ((out_current < s_reg.lim_thr && !reg_wr) |=> s_reg.lim_secs == 6'h0)
    else $error("limit timer not cleared");
  a_fb_ends: assert property ((feedback_raw == 12'hfff && $stable(s_reg.fb_low) && $stable(s_reg.fb_high))
    |=> s_reg.fb_scaled == s_reg.fb_high)
    else $error("feedback full scale does not reach high value");
  a_mains_trip_due: assert property ((mains_expire && !reg_wr &&
    s_reg.mains_sel == fault_resp_pkg::MAINS_TRIP) |=> motor_stop)
    else $error("mains trip not taken after delay");
  a_mains_idle: assert property ((!mains_fault) |=> s_reg.mains_secs == 4'h0)
    else $error("mains timer not cleared");
  a_ot_cap_step: assert property ((s_reg.ot == fault_resp_pkg::OT_CURBACK) |=>
    cur_cap <= $past(s_reg.ot_cap))
    else $error("overtemperature current cap exceeded");
  a_ot_warn: assert property ((s_reg.ot != fault_resp_pkg::OT_NORMAL) |=> warning && derate)
    else $error("overtemperature derating without warning");
  a_filter_keep_sw: assert property ((s_reg.noise_sel == fault_resp_pkg::NOISE_FILTER) |=>
    sw_freq == $past(s_reg.sw_set))
    else $error("filter mode changed switching frequency");
  a_trip_latch: assert property ((motor_stop && !reg_wr) |=> motor_stop && alarm)
    else $error("trip released without clear");

  // main scenarios

  c_mains_trip: cover property (mains_fault && s_reg.mains_sel == fault_resp_pkg::MAINS_TRIP ##1 motor_stop);
  c_ot_curback: cover property (s_reg.ot == fault_resp_pkg::OT_CURBACK);
  c_limit_cut: cover property (lim_expire ##1 motor_stop);
  c_irq_raise: cover property (!irq ##1 irq);
  c_fixed_derate: cover property (s_reg.noise_sel == fault_resp_pkg::NOISE_FIXED && derate);
endmodule

`default_nettype wire

/* monitor_model.sv */
// behavioural model of the power stage and the current, mains and temperature monitors
`timescale 1ns/1ps
`default_nettype none
module monitor_model (
  // clock
  input wire logic core_clk,
  // plant levels set by the test
  input wire logic [15:0] load_level,
  input wire logic [15:0] speed_req,
  input wire logic mains_bad,
  input wire logic hot,
  input wire logic [11:0] fb_level,
  // monitor readings into the drive
  output logic [15:0] out_current,
  output logic [15:0] freq_cmd,
  output logic mains_fault,
  output logic overtemp,
  output logic [11:0] feedback_raw
);
  // sensors report one cycle after the plant changes
  always_ff @(posedge core_clk) begin
    out_current <= load_level;
    freq_cmd <= speed_req;
    mains_fault <= mains_bad;
    overtemp <= hot;
    feedback_raw <= fb_level;
  end
endmodule
`default_nettype wire

/* tb.sv */
// testbench for the drive fault response block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = 20;
  logic core_clk, srst, reg_wr, reg_rd, mains_bad, hot, mains_fault, overtemp;
  logic motor_stop, warning, alarm, derate, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] load_level, speed_req, out_current, freq_cmd, sw_freq, freq_out, cur_cap;
  logic [11:0] fb_level, feedback_raw;
  logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30};
  logic [31:0] rv [7] = '{32'h4, 32'h3d, 32'h0, 32'h186a0, 32'hffff, 32'h3e8, 32'h0};
  logic [11:0] fr [3] = '{12'h000, 12'h800, 12'hfff};
  logic [31:0] fe [3] = '{32'hfffffc18, 32'h3e8, 32'hbb8};
  int n_fail = 0;
  int checked = 0;
  drive_fault_response #(.TICK_CYCLES(TK)) drive_fault_response_inst (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_current(out_current), .freq_cmd(freq_cmd), .mains_fault(mains_fault), .overtemp(overtemp),
    .feedback_raw(feedback_raw), .sw_freq(sw_freq), .freq_out(freq_out), .cur_cap(cur_cap),
    .motor_stop(motor_stop), .warning(warning), .alarm(alarm), .derate(derate), .irq(irq));
  monitor_model monitor_model_inst (.core_clk(core_clk), .load_level(load_level), .speed_req(speed_req),
    .mains_bad(mains_bad), .hot(hot), .fb_level(fb_level), .out_current(out_current), .freq_cmd(freq_cmd),
    .mains_fault(mains_fault), .overtemp(overtemp), .feedback_raw(feedback_raw));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    srst <= 1'b1;
    load_level <= 16'd500;
    mains_bad <= 1'b0;
    hot <= 1'b0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {srst, reg_wr, reg_rd, mains_bad, hot, reg_addr, reg_wdata, load_level, speed_req, fb_level} = '0;
    srst = 1'b1;
    do_reset();
    foreach (ra[i]) begin
      rd(ra[i]);
      check("reset value", d, rv[i]);
    end
    speed_req <= 16'd1000;
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h4 + m);
      wr(8'h04, 32'h1770);
      cyc(4);
      check("sw_freq", sw_freq, 16'h1770);
      check("derate", derate, m != 0);
      check("freq_out", freq_out, 16'd600);
    end
    wr(8'h00, 32'h5);
    wr(8'h04, 32'hbb8);
    cyc(4);
    check("low sw_freq", sw_freq, 16'hbb8);
    check("low derate", derate, 1'b0);
    check("low freq_out", freq_out, 16'd300);
    do_reset();
    wr(8'h14, 32'h0064ffff);
    load_level <= 16'd50;
    cyc(4);
    check("no-load warn", {warning, motor_stop, irq}, 3'b100);
    wr(8'h28, 32'h2);
    cyc(2);
    check("irq", irq, 1'b1);
    wr(8'h00, 32'h0);
    cyc(3);
    check("no-load trip", {motor_stop, alarm}, 2'b11);
    rd(8'h1c);
    check("no-load cause", d[3:0], 4'h3);
    load_level <= 16'd500;
    wr(8'h00, 32'h104);
    wr(8'h24, 32'h1f);
    cyc(2);
    check("cleared", {motor_stop, irq}, 2'b00);
    rd(8'h20);
    check("irq status", d, 32'h0);
    do_reset();
    mains_bad <= 1'b1;
    cyc(TK);
    check("mains early", motor_stop, 1'b0);
    cyc(3 * TK);
    rd(8'h1c);
    check("mains trip", {motor_stop, d[3:0]}, 5'h15);
    do_reset();
    wr(8'h00, 32'h14);
    mains_bad <= 1'b1;
    cyc(4);
    check("mains warn", {warning, motor_stop}, 2'b10);
    wr(8'h00, 32'h0c);
    cyc(3);
    check("mains derate", {warning, derate, motor_stop}, 3'b110);
    check("mains cap", cur_cap, 16'd300);
    do_reset();
    hot <= 1'b1;
    cyc(3);
    rd(8'h1c);
    check("ot trip", {motor_stop, alarm, d[3:0]}, 6'h37);
    do_reset();
    wr(8'h00, 32'h25);
    wr(8'h04, 32'h1770);
    wr(8'h14, 32'h3e8);
    hot <= 1'b1;
    cyc(3);
    check("ot sw", sw_freq, 16'h7d0);
    check("ot flags", {warning, derate, motor_stop}, 3'b110);
    cyc(3 * TK);
    check("ot cap", cur_cap < 16'd1000, 1'b1);
    do_reset();
    wr(8'h14, 32'h3e8);
    load_level <= 16'd1000;
    cyc(63 * TK);
    check("limit off", motor_stop, 1'b0);
    load_level <= 16'd500;
    wr(8'h08, 32'h2);
    load_level <= 16'd1000;
    cyc(15);
    load_level <= 16'd500;
    cyc(4);
    load_level <= 16'd1000;
    cyc(TK + 5);
    check("limit cleared", motor_stop, 1'b0);
    cyc(3 * TK);
    rd(8'h1c);
    check("limit trip", {motor_stop, d[3:0]}, 5'h19);
    do_reset();
    wr(8'h0c, 32'hfffffc18);
    wr(8'h10, 32'hbb8);
    foreach (fr[i]) begin
      fb_level <= fr[i];
      cyc(3);
      rd(8'h2c);
      check("fb scaled", d, fe[i]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
